// ===== logic/crm_rate_mode.sv
// per-channel rate selection, divider search and frequency lock qualification
`default_nettype none
module crm_rate_mode
    import crm_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter logic [14:0] DEF_COUNT = 15'h3200
) (
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // per-channel analog side
    input wire logic [NUM_CH-1:0] sig_detect,
    input wire logic [NUM_CH-1:0] meas_valid,
    input wire logic [NUM_CH-1:0][14:0] meas_count,
    output var crm_stat_s [NUM_CH-1:0] ch_status
);
    localparam int CHW = $clog2(NUM_CH);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (NUM_CH < 2 || NUM_CH > 8) begin : g_bad
        $error("crm_rate_mode: NUM_CH must lie in 2..8");
    end

    // ------------------------------------------------------------
    // per-channel register copies
    // ------------------------------------------------------------
    logic [7:0] chsel_r;
    logic [7:0] crst_r [NUM_CH];
    logic [7:0] rate_r [NUM_CH];
    logic [7:0] refm_r [NUM_CH];
    logic [7:0] g0l_r [NUM_CH];
    logic [7:0] g0h_r [NUM_CH];
    logic [7:0] g1l_r [NUM_CH];
    logic [7:0] g1h_r [NUM_CH];
    logic [7:0] tol_r [NUM_CH];
    logic [7:0] rdata_r;

    wire logic [CHW-1:0] sel_w = chsel_r[CHW-1:0];
    wire logic sel_ok_w = chsel_r < 8'(NUM_CH);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chsel_r <= ZERO8;
        end else if (reg_wr && reg_addr == OFS_CHSEL) begin
            chsel_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                crst_r[c] <= ZERO8;
                rate_r[c] <= RATE_RST;
                refm_r[c] <= REFM_RST;
                g0l_r[c] <= ZERO8;
                g0h_r[c] <= ZERO8;
                g1l_r[c] <= ZERO8;
                g1h_r[c] <= ZERO8;
                tol_r[c] <= ZERO8;
            end else if (reg_wr && sel_ok_w && sel_w == CHW'(c)) begin
                if (reg_addr == OFS_CRST) crst_r[c] <= reg_wdata;
                if (reg_addr == OFS_RATE) rate_r[c] <= reg_wdata;
                if (reg_addr == OFS_REFM) refm_r[c] <= reg_wdata;
                if (reg_addr == OFS_G0L) g0l_r[c] <= reg_wdata;
                if (reg_addr == OFS_G0H) g0h_r[c] <= reg_wdata;
                if (reg_addr == OFS_G1L) g1l_r[c] <= reg_wdata;
                if (reg_addr == OFS_G1H) g1h_r[c] <= reg_wdata;
                if (reg_addr == OFS_TOL) tol_r[c] <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // read path, registered; other offsets and absent channels read 0
    // ------------------------------------------------------------
    wire logic [7:0] stat_rd_w = {ch_status[sel_w].lock,
                                  ch_status[sel_w].group,
                                  ch_status[sel_w].auto_cap, 1'b0,
                                  ch_status[sel_w].div};
    wire logic [7:0] rd_w =
        (reg_addr == OFS_CHSEL) ? chsel_r :
        !sel_ok_w ? ZERO8 :
        (reg_addr == OFS_STATUS) ? stat_rd_w :
        (reg_addr == OFS_CRST) ? crst_r[sel_w] :
        (reg_addr == OFS_RATE) ? rate_r[sel_w] :
        (reg_addr == OFS_REFM) ? refm_r[sel_w] :
        (reg_addr == OFS_G0L) ? g0l_r[sel_w] :
        (reg_addr == OFS_G0H) ? g0h_r[sel_w] :
        (reg_addr == OFS_G1L) ? g1l_r[sel_w] :
        (reg_addr == OFS_G1H) ? g1h_r[sel_w] :
        (reg_addr == OFS_TOL) ? tol_r[sel_w] : ZERO8;

    always_ff @(posedge clk_sys) begin
        if (reset) rdata_r <= ZERO8;
        else rdata_r <= rd_w;
    end
    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // signal detect synchroniser, the pin is asynchronous
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] sd_meta_r;
    logic [NUM_CH-1:0] sd_sync_r;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sd_meta_r <= '0;
            sd_sync_r <= '0;
        end else begin
            sd_meta_r <= sig_detect;
            sd_sync_r <= sd_meta_r;
        end
    end

    // ------------------------------------------------------------
    // per-channel decode of mode, divider sets and counts
    // ------------------------------------------------------------
    logic [3:0] m0_w [NUM_CH];
    logic [3:0] m1_w [NUM_CH];
    logic two_w [NUM_CH];
    logic auto_w [NUM_CH];
    logic frange_w [NUM_CH];
    logic cdr_rst_w [NUM_CH];
    logic [14:0] exp_w [NUM_CH];
    logic [3:0] tolv_w [NUM_CH];
    logic hit_w [NUM_CH];
    logic [2:0] first_w [NUM_CH];
    logic [2:0] next_w [NUM_CH];

    crm_state_e st_r [NUM_CH];
    logic [2:0] cand_r [NUM_CH];
    logic match1_r [NUM_CH];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_dec
        wire logic [3:0] nib = rate_r[c][7:4];
        wire logic [3:0] raw0 = crm_div_mask(nib, 1'b0);
        wire logic [3:0] raw1 = crm_div_mask(nib, 1'b1);
        // unmapped codes run frequency-range mode on a forced divider
        assign frange_w[c] = (raw0 == DVNONE);
        assign m0_w[c] = frange_w[c] ? (DV1 << refm_r[c][1:0])
                                     : raw0;
        assign m1_w[c] = frange_w[c] ? DVNONE : raw1;
        assign auto_w[c] = refm_r[c][5:4] == REFM_AUTO;
        // two-group search needs the reference; never across FC plans
        assign two_w[c] = auto_w[c] && !frange_w[c]
                          && nib != STD_FC[7:4];
        assign cdr_rst_w[c] = crst_r[c][3:2] == CRST_ON;
        // manual flag clear falls back to the default count
        assign exp_w[c] = cand_r[c][2] ?
            (g1h_r[c][MAN_BIT] ? {g1h_r[c][6:0], g1l_r[c]} : DEF_COUNT) :
            (g0h_r[c][MAN_BIT] ? {g0h_r[c][6:0], g0l_r[c]} : DEF_COUNT);
        assign tolv_w[c] = cand_r[c][2] ? tol_r[c][7:4] : tol_r[c][3:0];
        assign hit_w[c] = crm_within(meas_count[c], exp_w[c],
                                     tolv_w[c]);
        assign first_w[c] = crm_next(3'b111, m0_w[c], m1_w[c], two_w[c]);
        assign next_w[c] = crm_next(cand_r[c], m0_w[c], m1_w[c],
                                    two_w[c]);
    end

    // ------------------------------------------------------------
    // lock search state machine, one per channel
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset || cdr_rst_w[c]) begin
                st_r[c] <= ST_HOLD;
                cand_r[c] <= 3'b000;
                match1_r[c] <= 1'b0;
            end else begin
                case (st_r[c])
                    ST_HOLD: begin
                        st_r[c] <= ST_SEARCH;
                        cand_r[c] <= first_w[c];
                        match1_r[c] <= 1'b0;
                    end
                    ST_SEARCH: begin
                        if (!crm_ok(cand_r[c], m0_w[c], m1_w[c], two_w[c]))
                        begin
                            cand_r[c] <= first_w[c];
                        end else if (meas_valid[c] && sd_sync_r[c]) begin
                            if (!hit_w[c]) begin
                                cand_r[c] <= next_w[c];
                                match1_r[c] <= 1'b0;
                            end else if (rate_r[c][FLOCK_BIT]
                                         || match1_r[c]) begin
                                st_r[c] <= ST_LOCKED;
                            end else begin
                                match1_r[c] <= 1'b1;
                            end
                        end
                    end
                    ST_LOCKED: begin
                        // loss of signal or a bad count drops the lock
                        if (!sd_sync_r[c] || (meas_valid[c] && !hit_w[c])
                            || !crm_ok(cand_r[c], m0_w[c], m1_w[c],
                                       two_w[c])) begin
                            st_r[c] <= ST_SEARCH;
                            match1_r[c] <= 1'b0;
                        end
                    end
                    default: st_r[c] <= ST_HOLD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                ch_status[c] <= '0;
            end else begin
                ch_status[c].lock <= st_r[c] == ST_LOCKED;
                ch_status[c].group <= cand_r[c][2];
                ch_status[c].div <= DV1 << cand_r[c][1:0];
                ch_status[c].auto_cap <= auto_w[c];
                // cap code tracks the expected count only with reference
                ch_status[c].cap_code <= auto_w[c] ? exp_w[c][14:8]
                                                   : 7'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions on channel 0
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_LOCK_NEEDS_SIG: assert property (
        st_r[0] == ST_LOCKED |-> $past(sd_sync_r[0]))
        else $error("lock held without signal");
    AST_LOCK_CAUSE: assert property (
        st_r[0] == ST_SEARCH && st_r[0] != ST_LOCKED ##1
        st_r[0] == ST_LOCKED |-> $past(meas_valid[0] && hit_w[0]))
        else $error("lock entered without matching count");
    AST_RST_DROPS: assert property (
        cdr_rst_w[0] |=> st_r[0] == ST_HOLD ##1 !ch_status[0].lock)
        else $error("loop reset did not drop lock");
    AST_RST_RESTART: assert property (
        $fell(cdr_rst_w[0]) |-> st_r[0] == ST_HOLD ##1 st_r[0] == ST_SEARCH)
        else $error("loop did not restart after reset");
    // a settings write leaves the old lock one cycle before it is dropped
    AST_DIV_ALLOWED: assert property (
        st_r[0] == ST_LOCKED && $stable(rate_r[0]) && $stable(refm_r[0])
        |-> crm_ok(cand_r[0], m0_w[0], m1_w[0], two_w[0]))
        else $error("locked on a divider outside the set");
    AST_FC_ONE_GROUP: assert property (
        st_r[0] == ST_LOCKED && rate_r[0][7:4] == STD_FC[7:4]
        && $stable(rate_r[0]) |-> !cand_r[0][2])
        else $error("fibre channel mode switched group");
    AST_FRANGE_FIXED: assert property (
        frange_w[0] && st_r[0] == ST_LOCKED
        && $stable(rate_r[0]) && $stable(refm_r[0])
        |-> cand_r[0] == {1'b0, refm_r[0][1:0]})
        else $error("frequency-range divider not fixed");
    AST_FLOCK_TWO_HITS: assert property (
        st_r[0] == ST_SEARCH ##1 st_r[0] == ST_LOCKED
        && !rate_r[0][FLOCK_BIT] && $stable(rate_r[0])
        |-> $past(match1_r[0]))
        else $error("false-lock check skipped");
    AST_REG_RESET: assert property (
        $fell(reset) |-> refm_r[0][5:4] == REFM_AUTO
        && rate_r[0][FLOCK_BIT])
        else $error("reference mode or false-lock bit reset wrong");
    AST_CAP_AUTO: assert property (
        auto_w[0] |=> ch_status[0].cap_code == $past(exp_w[0][14:8]))
        else $error("cap code not derived from count");

    COV_LOCK: cover property (st_r[0] == ST_SEARCH ##1 st_r[0] == ST_LOCKED);
    COV_GROUP1_LOCK: cover property (st_r[0] == ST_LOCKED && cand_r[0][2]);
    COV_RELOCK: cover property ($fell(cdr_rst_w[0]) ##[1:200]
                                st_r[0] == ST_LOCKED);
endmodule : crm_rate_mode
`default_nettype wire

// ===== logic/crm_pkg.sv
// constants, types and helpers for the rate mode and lock qualification block
// How it works
// - rate-standard register takes a fixed code per standard, 0x06 through 0xD6
// - a programmed standard restricts the coarse tuning and divider search
// - upper nibble zero: divide-by-8 for 1.25G, divide-by-1 for 10.3125G
// - upper nibble code maps to a divider set for each frequency group
// - no automatic switch between the two Fibre Channel oscillator plans
// - single-frequency standards walk divider ratios with no register change
// - lock only when measured count is within tolerance of expected count
// - group 0 count at group0_expected_count_low/group0_expected_count_high, group 1 at group1_expected_count_low/group1_expected_count_high, tolerance count_tolerance
// - count low byte in even register, high 7 bits plus manual flag odd
// - tolerance register holds two 4-bit tolerances, one per nibble
// - reference mode 2'b11 uses reference and derives cap codes itself
// - reference mode allows divider switching across both groups
// - setting then clearing bits 3:2 of cdr_reset_control resets and restarts the loop
// - after configuration the channel locks to a signal at an allowed rate
// - frequency-range mode uses a fixed divider, 1 unless forced
// - rate bit 1 resets to 1, disabling false-lock detection; 0 enables
// - reference mode field resets to 2'b11
`default_nettype none
package crm_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h02;
    localparam logic [7:0] OFS_CRST = 8'h0a;
    localparam logic [7:0] OFS_RATE = 8'h2f;
    localparam logic [7:0] OFS_REFM = 8'h36;
    localparam logic [7:0] OFS_G0L = 8'h60;
    localparam logic [7:0] OFS_G0H = 8'h61;
    localparam logic [7:0] OFS_G1L = 8'h62;
    localparam logic [7:0] OFS_G1H = 8'h63;
    localparam logic [7:0] OFS_TOL = 8'h64;
    localparam logic [7:0] OFS_CHSEL = 8'hff;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] REFM_RST = 8'h30;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam int FLOCK_BIT = 1;
    localparam int MAN_BIT = 7;
    localparam logic [1:0] REFM_AUTO = 2'b11;
    localparam logic [1:0] CRST_ON = 2'b11;
    // standard codes for the rate-standard register
    localparam logic [7:0] STD_ETH = 8'h06;
    localparam logic [7:0] STD_FC = 8'h16;
    localparam logic [7:0] STD_IB = 8'h26;
    localparam logic [7:0] STD_SONET = 8'h56;
    localparam logic [7:0] STD_PROP_A = 8'h76;
    localparam logic [7:0] STD_PROP_B = 8'h86;
    localparam logic [7:0] STD_ILKN = 8'hc6;
    localparam logic [7:0] STD_SFF = 8'hd6;
    // divider masks, bit i stands for ratio 2**i
    localparam logic [3:0] DV1 = 4'h1;
    localparam logic [3:0] DV2 = 4'h2;
    localparam logic [3:0] DV4 = 4'h4;
    localparam logic [3:0] DV8 = 4'h8;
    localparam logic [3:0] DVNONE = 4'h0;

    typedef enum logic [1:0] {ST_HOLD, ST_SEARCH, ST_LOCKED} crm_state_e;

    typedef struct packed {
        logic lock;
        logic group;
        logic [3:0] div;
        logic auto_cap;
        logic [6:0] cap_code;
    } crm_stat_s;

    // divider set of one group for an upper-nibble code
    function automatic logic [3:0] crm_div_mask(input logic [3:0] nib,
                                                input logic grp);
        case (nib)
            STD_ETH[7:4]: crm_div_mask = grp ? DV1 : DV8;
            STD_FC[7:4]: crm_div_mask = grp ? DV1 : (DV1|DV2|DV4);
            STD_IB[7:4]: crm_div_mask = DV1 | DV2 | DV4;
            4'h4: crm_div_mask = DV2 | DV4;
            STD_SONET[7:4]: crm_div_mask = DV1 | DV4;
            4'h6: crm_div_mask = DV1 | DV2 | DV4 | DV8;
            4'ha: crm_div_mask = DV2;
            STD_PROP_A[7:4], STD_PROP_B[7:4], STD_ILKN[7:4],
            STD_SFF[7:4]: crm_div_mask = DV1;
            default: crm_div_mask = DVNONE;
        endcase
    endfunction : crm_div_mask

    // candidate k = {group, divider index} is permitted
    function automatic logic crm_ok(input logic [2:0] k,
                                    input logic [3:0] m0,
                                    input logic [3:0] m1,
                                    input logic two);
        crm_ok = k[2] ? (two && m1[k[1:0]]) : m0[k[1:0]];
    endfunction : crm_ok

    // next permitted candidate after cur, wrapping; cur if none other
    function automatic logic [2:0] crm_next(input logic [2:0] cur,
                                            input logic [3:0] m0,
                                            input logic [3:0] m1,
                                            input logic two);
        logic [2:0] k;
        logic found;
        crm_next = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            k = cur + 3'(i);
            if (!found && crm_ok(k, m0, m1, two)) begin
                crm_next = k;
                found = 1'b1;
            end
        end
    endfunction : crm_next

    // measured count within tolerance of expected count
    function automatic logic crm_within(input logic [14:0] meas,
                                        input logic [14:0] expc,
                                        input logic [3:0] tol);
        logic [14:0] d;
        d = (meas > expc) ? (meas - expc) : (expc - meas);
        crm_within = d <= {11'h000, tol};
    endfunction : crm_within
endpackage : crm_pkg
`default_nettype wire

// ===== verif/crm_rate_mode_tb_top.sv
// self-checking bench for the rate mode and lock qualification block
`default_nettype none
module crm_rate_mode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import crm_pkg::*;
    localparam int NCH = 2;
    logic clk_sys, reset, reg_wr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [NCH-1:0] sig_detect, meas_valid;
    logic [NCH-1:0][14:0] meas_count;
    crm_stat_s [NCH-1:0] ch_status;
    logic [15:0] lfsr = 16'h0011;
    logic [7:0] regs [7] = '{OFS_CRST, OFS_RATE, OFS_REFM, OFS_G0L,
                             OFS_G0H, OFS_G1L, OFS_G1H};
    logic [7:0] std_codes [11] = '{STD_ETH, STD_FC, STD_IB, STD_SONET,
                                   STD_PROP_A, STD_PROP_B, STD_ILKN,
                                   STD_SFF, 8'h46, 8'ha6, 8'h32};
    logic [7:0] shadow [NCH][7];
    int n_mismatch = 0;
    int compares = 0;

    crm_rate_mode #(.NUM_CH(NCH)) crm_rate_mode_i (
        .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sig_detect(sig_detect), .meas_valid(meas_valid),
        .meas_count(meas_count), .ch_status(ch_status)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_step

    // lowest group 0 ratio, one-hot; frequency-range codes use ratio 1
    function automatic logic [3:0] low_div(input logic [3:0] nib);
        case (nib)
            4'h0: return 4'h8;
            4'h4, 4'ha: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction : low_div

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk_sys) #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys) #1;
        reg_addr = a;
        @(posedge clk_sys) #1;
        check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask : rd_chk

    task automatic meas(input logic [14:0] v);
        @(posedge clk_sys) #1;
        meas_valid[0] = 1'b1;
        meas_count[0] = v;
        @(posedge clk_sys) #1;
        meas_valid[0] = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : meas

    task automatic cfg(input logic [7:0] rate, input logic [7:0] refm,
                       input logic [14:0] c0, input logic [14:0] c1);
        wr(OFS_REFM, refm);
        wr(OFS_RATE, rate);
        wr(OFS_G0L, c0[7:0]);
        wr(OFS_G0H, {1'b1, c0[14:8]});
        wr(OFS_G1L, c1[7:0]);
        wr(OFS_G1H, {1'b1, c1[14:8]});
        wr(OFS_TOL, 8'hff);
        wr(OFS_CRST, 8'h0c);
        wr(OFS_CRST, 8'h00);
        repeat (4) @(posedge clk_sys);
    endtask : cfg

    task automatic stat(input logic lk, input logic g, input logic [3:0] dv);
        check("lock", {15'h0, lk}, {15'h0, ch_status[0].lock});
        check("group", {15'h0, g}, {15'h0, ch_status[0].group});
        check("div", {12'h0, dv}, {12'h0, ch_status[0].div});
    endtask : stat

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // hang guard: the whole run is far shorter than this
    initial begin
        #(100 * 30000);
        n_mismatch++;
        wrap_up();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sig_detect = '0;
        meas_valid = '0;
        meas_count = '0;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        rd_chk(OFS_RATE, RATE_RST);
        rd_chk(OFS_REFM, REFM_RST);
        rd_chk(OFS_TOL, 8'h00);
        rd_chk(OFS_G1H, 8'h00);
        wr(8'h50, 8'h5a);
        rd_chk(8'h50, 8'h00);
        // per-channel copies hold random contents independently
        for (int c = 0; c < NCH; c++) begin
            wr(OFS_CHSEL, 8'(c));
            for (int r = 0; r < 7; r++) begin
                lfsr = lfsr_step(lfsr);
                shadow[c][r] = lfsr[7:0];
                wr(regs[r], lfsr[7:0]);
            end
        end
        for (int c = 0; c < NCH; c++) begin
            wr(OFS_CHSEL, 8'(c));
            rd_chk(OFS_CHSEL, 8'(c));
            for (int r = 0; r < 7; r++) rd_chk(regs[r], shadow[c][r]);
        end
        wr(OFS_CHSEL, 8'h02);
        rd_chk(OFS_RATE, 8'h00);
        wr(OFS_CHSEL, 8'h00);
        sig_detect = 2'b01;
        // every standard code locks at its lowest group 0 ratio
        foreach (std_codes[i]) begin
            cfg(std_codes[i], REFM_RST, 15'h3200, 15'h3200);
            rd_chk(OFS_RATE, std_codes[i]);
            lfsr = lfsr_step(lfsr);
            meas(lfsr[4] ? 15'h3200 + 15'(lfsr[3:0] & 4'hf)
                         : 15'h3200 - 15'(lfsr[3:0]));
            stat(1'b1, 1'b0, low_div(std_codes[i][7:4]));
            check("cap", 16'h00b2, {8'h0, ch_status[0].auto_cap,
                  ch_status[0].cap_code});
        end
        // two groups: a miss on group 0 moves to group 1 at ratio 1
        cfg(STD_ETH, REFM_RST, 15'h3200, 15'h3390);
        meas(15'h3210);
        stat(1'b0, 1'b1, 4'h1);
        meas(15'h3390 - 15'd15);
        stat(1'b1, 1'b1, 4'h1);
        rd_chk(OFS_STATUS, 8'he1);
        // a miss while locked drops the lock, the next miss moves on
        meas(15'h3390 + 15'd16);
        stat(1'b0, 1'b1, 4'h1);
        meas(15'h3390 + 15'd16);
        stat(1'b0, 1'b0, 4'h8);
        // the dual-plan standard walks ratios in group 0 only
        cfg(STD_FC, REFM_RST, 15'h2a80, 15'h3390);
        meas(15'h0100);
        stat(1'b0, 1'b0, 4'h2);
        meas(15'h0100);
        stat(1'b0, 1'b0, 4'h4);
        meas(15'h0100);
        stat(1'b0, 1'b0, 4'h1);
        // frequency range without reference: forced ratio, no cap codes
        cfg(8'h32, 8'h02, 15'h2a80, 15'h2a80);
        meas(15'h2a80);
        stat(1'b1, 1'b0, 4'h4);
        check("auto", 16'h0, {8'h0, ch_status[0].auto_cap,
              ch_status[0].cap_code});
        // false-lock detector on: one hit is not enough
        cfg(8'h04, REFM_RST, 15'h3200, 15'h3390);
        meas(15'h3200);
        stat(1'b0, 1'b0, 4'h8);
        meas(15'h3200);
        stat(1'b1, 1'b0, 4'h8);
        wr(OFS_CRST, 8'h0c);
        repeat (2) @(posedge clk_sys);
        #1;
        stat(1'b0, 1'b0, 4'h1);
        wr(OFS_CRST, 8'h00);
        repeat (4) @(posedge clk_sys);
        meas(15'h3200);
        meas(15'h3200);
        stat(1'b1, 1'b0, 4'h8);
        sig_detect = 2'b00;
        repeat (5) @(posedge clk_sys);
        #1;
        check("lock", 16'h0, {15'h0, ch_status[0].lock});
        check("lock1", 16'h0, {15'h0, ch_status[1].lock});
        wrap_up();
    end
endmodule : crm_rate_mode_tb_top
`default_nettype wire
